//--- logic/fma_special.sv
// fused multiply-add result selection, rounding and exceptions
// assumes operands from the issuing pipeline on the same clock
`timescale 1ns/1ns
`include "fma_regs.svh"

module fma_special #(
    parameter int EW = `FMA_EXP_W,
    parameter int FW = `FMA_FRAC_W
) (
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rstn,
    // operation request
    input  wire logic                  i_valid,
    input  wire logic                  i_neg_prod,
    input  wire logic                  i_neg_add,
    input  wire logic [1:0]            i_rmode,
    input  wire logic [EW+FW:0]        i_x,
    input  wire logic [EW+FW:0]        i_y,
    input  wire logic [EW+FW:0]        i_z,
    input  wire logic [EW+FW:0]        i_dst_old,
    input  wire logic [`FMA_FLG_W-1:0] i_mask,
    // status and identification
    input  wire logic                  i_status_clr,
    input  wire logic [31:0]           i_id_leaf,
    // result
    output logic                       o_valid,
    output logic [EW+FW:0]             o_result,
    output logic [`FMA_FLG_W-1:0]      o_flags,
    output logic                       o_fault,
    output logic                       o_invalid_status,
    output logic [31:0]                o_id_word
);

    localparam int N   = EW + FW + 1;
    localparam int M   = FW + 1;
    localparam int W   = 3 * M + 4;
    localparam int SW  = $clog2(W + 2);
    localparam int EXW = EW + 4;
    localparam logic signed [EXW-1:0] BIAS  = EXW'(2 ** (EW - 1) - 1);
    localparam logic signed [EXW-1:0] E_OFF = EXW'(FW + 6);
    localparam logic signed [EXW-1:0] S_TOP = EXW'(2 * M + 3);
    localparam logic signed [EXW-1:0] E_MAX = EXW'(2 ** EW - 1);
    localparam logic [N-1:0] DQNAN =
        {1'b1, {EW{1'b1}}, 1'b1, {(FW-1){1'b0}}};
    localparam logic [N-2:0] INF_M = {{EW{1'b1}}, {FW{1'b0}}};
    localparam logic [N-2:0] MAX_M = {{(EW-1){1'b1}}, 1'b0, {FW{1'b1}}};

    if (EW < 3 || FW < 2 || EW > 15) begin : g_bad
        $error("fma_special: unsupported operand format");
    end

    ////////////////////////////////////////////////////////////////////////
    // operand classification, index 0 x, 1 y, 2 z
    logic [N-1:0]  op    [3];
    logic [N-1:0]  quiet [3];
    logic [FW:0]   mant  [3];
    logic [EW-1:0] expo  [3];
    logic [2:0]    nan;
    logic [2:0]    snan;
    logic [2:0]    inf;
    logic [2:0]    zero;
    logic [2:0]    sub;

    assign op[0] = i_x;
    assign op[1] = i_y;
    assign op[2] = i_z;

    for (genvar g = 0; g < 3; g++) begin : g_cls
        fma_class #(.EW(EW), .FW(FW)) u_cls (
            .i_op    (op[g]),
            .o_nan   (nan[g]),
            .o_snan  (snan[g]),
            .o_inf   (inf[g]),
            .o_zero  (zero[g]),
            .o_sub   (sub[g]),
            .o_quiet (quiet[g]),
            .o_mant  (mant[g]),
            .o_exp   (expo[g])
        );
    end

    // effective signs of product and addend
    fma_pkg::fma_rmode_t rm;
    logic sp;
    logic sz;
    logic eff_sub;
    logic rd;

    assign rm      = fma_pkg::fma_rmode_t'(i_rmode);
    assign sp      = i_x[N-1] ^ i_y[N-1] ^ i_neg_prod;
    assign sz      = i_z[N-1] ^ i_neg_add;
    assign eff_sub = sp ^ sz;
    assign rd      = (rm == fma_pkg::FMA_RM_DOWN);

    ////////////////////////////////////////////////////////////////////////
    // leading zero count of the exact sum
    function automatic logic [SW-1:0] lzc_f(input logic [W:0] v);
        logic [SW-1:0] n;
        logic          hit;
        n   = '0;
        hit = 1'b0;
        for (int i = W; i >= 0; i--) begin
            if (!hit && !v[i]) begin
                n = n + SW'(1);
            end else begin
                hit = 1'b1;
            end
        end
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // exact product, aligned addend, one rounding
    logic [2*M-1:0]        prod;
    logic signed [EXW-1:0] sh;
    logic [SW-1:0]         sh_u;
    logic [W-1:0]          a_fr;
    logic [W-1:0]          z_top;
    logic [W-1:0]          b_fr;
    logic [W:0]            mag;
    logic                  msign;
    logic                  mag_zero;
    logic [SW-1:0]         lz;
    logic [W:0]            norm;
    logic signed [EXW-1:0] er;
    logic [M+1:0]          t;
    logic [M+1:0]          t2;
    logic [SW-1:0]         dsh;
    logic [N-2:0]          rnd;
    logic                  inc;
    logic                  ovf;
    logic                  inexact;
    logic [N-1:0]          fin_res;
    logic [`FMA_FLG_W-1:0] fin_flg;

    always_comb begin
        // product held exact, no rounding before the add
        prod  = mant[0] * mant[1];
        sh    = S_TOP - ({4'h0, expo[2]} - {4'h0, expo[0]}
              - {4'h0, expo[1]} + BIAS + EXW'(FW));
        sh_u  = (sh <= 0) ? '0 : (sh >= EXW'(W)) ? SW'(W) : sh[SW-1:0];
        a_fr  = {{(M+3){1'b0}}, prod, 1'b0};
        z_top = {mant[2], {(2*M+4){1'b0}}};
        // shifted-out addend bits kept as sticky
        b_fr  = (z_top >> sh_u)
              | {{(W-1){1'b0}}, |(z_top & ~({W{1'b1}} << sh_u))};
        if (!eff_sub) begin
            mag   = {1'b0, a_fr} + {1'b0, b_fr};
            msign = sp;
        end else if (a_fr >= b_fr) begin
            mag   = {1'b0, a_fr - b_fr};
            msign = sp;
        end else begin
            mag   = {1'b0, b_fr - a_fr};
            msign = sz;
        end
        mag_zero = ~|mag;
        lz   = lzc_f(mag);
        norm = mag << lz;
        // addend far above the product: lift exponent by the clamped shift
        er   = {4'h0, expo[0]} + {4'h0, expo[1]} - BIAS + E_OFF
             - {{(EXW-SW){1'b0}}, lz} + ((sh < 0) ? -sh : EXW'(0));
        t    = {norm[W:W-M], |norm[W-M-1:0]};
        // tiny results shifted into the subnormal range
        dsh  = (er > 0) ? '0 : (EXW'(1) - er > EXW'(M + 2)) ?
               SW'(M + 2) : SW'(EXW'(1) - er);
        t2   = (t >> dsh) | {{(M+1){1'b0}},
               |(t & ~({(M+2){1'b1}} << dsh))};
        unique case (rm)
            fma_pkg::FMA_RM_NEAR: inc = t2[1] & (t2[0] | t2[2]);
            fma_pkg::FMA_RM_DOWN: inc = (t2[1] | t2[0]) & msign;
            fma_pkg::FMA_RM_UP:   inc = (t2[1] | t2[0]) & ~msign;
            fma_pkg::FMA_RM_ZERO: inc = 1'b0;
        endcase
        // carry from the fraction walks into the exponent
        rnd = {(er > 0) ? er[EW-1:0] : EW'(0), t2[M:2]}
            + {{(N-2){1'b0}}, inc};
        ovf = (er >= E_MAX) | (&rnd[N-2:FW]);
        inexact = t2[1] | t2[0] | ovf;
        fin_flg = '0;
        fin_flg[`FMA_FLG_OE] = ovf;
        fin_flg[`FMA_FLG_UE] = (er <= 0) & inexact;
        fin_flg[`FMA_FLG_PE] = inexact;
        if (mag_zero) begin
            // like signs keep it, cancellation follows the mode
            fin_res = {eff_sub ? rd : sp, {(N-1){1'b0}}};
            fin_flg = '0;
        end else if (ovf) begin
            fin_res = {msign, (rm == fma_pkg::FMA_RM_ZERO
                      || (rd && !msign)
                      || (rm == fma_pkg::FMA_RM_UP && msign))
                      ? MAX_M : INF_M};
        end else begin
            fin_res = {msign, rnd};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // special operand selection by priority
    logic                  prod_inf;
    logic                  inf_zero;
    logic [N-1:0]          res_c;
    logic [`FMA_FLG_W-1:0] flg_c;
    logic                  fault_c;

    assign prod_inf = inf[0] | inf[1];
    assign inf_zero = (inf[0] & zero[1]) | (zero[0] & inf[1]);

    always_comb begin
        flg_c = '0;
        if (nan[0]) begin
            res_c = quiet[0];
            flg_c[`FMA_FLG_IE] = |snan;
        end else if (nan[1]) begin
            res_c = quiet[1];
            flg_c[`FMA_FLG_IE] = snan[1] | snan[2];
        end else if (nan[2]) begin
            res_c = quiet[2];
            flg_c[`FMA_FLG_IE] = snan[2];
        end else if (inf_zero) begin
            res_c = DQNAN;
            flg_c[`FMA_FLG_IE] = 1'b1;
        end else if (prod_inf && inf[2] && eff_sub) begin
            res_c = DQNAN;
            flg_c[`FMA_FLG_IE] = 1'b1;
        end else if (prod_inf) begin
            res_c = {sp, INF_M};
        end else if (inf[2]) begin
            res_c = {sz, INF_M};
        end else begin
            res_c = fin_res;
            flg_c = fin_flg;
            flg_c[`FMA_FLG_DE] = |sub;
        end
        fault_c = |(flg_c & ~i_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // output and status registers
    logic                  valid_r;
    logic                  valid_nxt;
    logic [N-1:0]          res_r;
    logic [N-1:0]          res_nxt;
    logic [`FMA_FLG_W-1:0] flg_r;
    logic [`FMA_FLG_W-1:0] flg_nxt;
    logic                  fault_r;
    logic                  fault_nxt;
    logic                  stat_r;
    logic                  stat_nxt;
    logic [31:0]           id_r;
    logic [31:0]           id_nxt;

    always_comb begin
        valid_nxt = i_valid;
        res_nxt   = res_r;
        flg_nxt   = '0;
        fault_nxt = 1'b0;
        if (i_valid) begin
            // destination kept when an unmasked exception traps
            res_nxt   = fault_c ? i_dst_old : res_c;
            flg_nxt   = flg_c;
            fault_nxt = fault_c;
        end
        // set wins over a clear in the same cycle
        stat_nxt = (stat_r & ~i_status_clr)
                 | (i_valid & flg_c[`FMA_FLG_IE]);
        id_nxt = (i_id_leaf == `FMA_ID_LEAF) ?
                 (32'h0000_0001 << `FMA_ID_BIT) : 32'h0000_0000;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            valid_r <= 1'b0;
            res_r   <= '0;
            flg_r   <= '0;
            fault_r <= 1'b0;
            stat_r  <= 1'b0;
            id_r    <= 32'h0000_0000;
        end else begin
            valid_r <= valid_nxt;
            res_r   <= res_nxt;
            flg_r   <= flg_nxt;
            fault_r <= fault_nxt;
            stat_r  <= stat_nxt;
            id_r    <= id_nxt;
        end
    end

    assign o_valid          = valid_r;
    assign o_result         = res_r;
    assign o_flags          = flg_r;
    assign o_fault          = fault_r;
    assign o_invalid_status = stat_r;
    assign o_id_word        = id_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic ok_c;
    assign ok_c = i_valid & ~fault_c;

    a_xnan_quiet: assert property (ok_c && nan[0] |=>
        o_result == ($past(i_x) | {{(EW+1){1'b0}}, 1'b1, {(FW-1){1'b0}}}))
        else $error("multiplicand nan not returned quieted");
    a_snan_invalid: assert property (i_valid && nan[0] && |snan |=>
        o_flags[`FMA_FLG_IE] && o_invalid_status)
        else $error("signalling nan did not flag invalid");
    a_ynan_quiet: assert property (ok_c && !nan[0] && nan[1] |=>
        o_result[FW-1] && o_result[N-1] == $past(i_y[N-1])
        && !o_flags[`FMA_FLG_IE] == !$past(snan[1] | snan[2]))
        else $error("multiplier nan result or flag wrong");
    a_znan_quiet: assert property (ok_c && nan == 3'b100 |=>
        o_result[FW-2:0] == $past(i_z[FW-2:0]) && o_result[FW-1])
        else $error("addend nan payload lost");
    a_inf_zero_nan: assert property (ok_c && inf_zero && !(|nan) |=>
        o_result == {1'b1, {EW{1'b1}}, 1'b1, {(FW-1){1'b0}}}
        && o_flags[`FMA_FLG_IE])
        else $error("infinity times zero not default nan");
    a_inf_sign: assert property (ok_c && prod_inf && !inf_zero
        && !(|nan) && !inf[2] |=> o_result[N-2:0] == INF_M
        && o_result[N-1] == ($past(i_x[N-1]) ^ $past(i_y[N-1])
        ^ $past(i_neg_prod)))
        else $error("infinite product sign wrong");
    a_addend_inf: assert property (ok_c && inf[2] && !prod_inf
        && !(|nan) |=> o_result == {$past(i_z[N-1] ^ i_neg_add), INF_M})
        else $error("infinite addend result wrong");
    a_cancel_sign: assert property (ok_c && !(|nan) && !(|inf)
        && mag_zero && eff_sub |=> o_result == {$past(rd), {(N-1){1'b0}}})
        else $error("cancelled zero sign wrong");
    a_fault_hold: assert property (i_valid && fault_c |=>
        o_fault && o_result == $past(i_dst_old))
        else $error("trapped result overwrote destination");
    a_status_keep: assert property (o_invalid_status
        && !i_status_clr |=> o_invalid_status [*1])
        else $error("invalid status flag dropped");
    a_id_bit: assert property (i_id_leaf == `FMA_ID_LEAF |=>
        o_id_word[`FMA_ID_BIT] ##1 1'b1)
        else $error("feature bit not reported");

    c_trap:    cover property (i_valid && fault_c ##1 o_fault);
    c_dqnan:   cover property (ok_c && prod_inf && inf[2] && eff_sub);
    c_cancel:  cover property (ok_c && mag_zero && eff_sub && rd);
    c_round:   cover property (ok_c && inc && !(|nan));

endmodule

//--- logic/fma_regs.svh
// constants for the fused multiply-add result and exception block
// assumes a binary interchange format: sign, biased exponent, fraction
`ifndef FMA_REGS_SVH
`define FMA_REGS_SVH

// default operand format
`define FMA_EXP_W   8
`define FMA_FRAC_W  23

// exception flag positions
`define FMA_FLG_W   5
`define FMA_FLG_IE  0
`define FMA_FLG_DE  1
`define FMA_FLG_OE  2
`define FMA_FLG_UE  3
`define FMA_FLG_PE  4

// identification leaf and feature bit
`define FMA_ID_LEAF 32'h0000_0001
`define FMA_ID_BIT  12

`endif

//--- logic/fma_pkg.sv
// types shared by the fused multiply-add block
// assumes the rounding-control field of the pipeline is two bits
package fma_pkg;

    // rounding-control field
    typedef enum logic [1:0] {
        FMA_RM_NEAR,
        FMA_RM_DOWN,
        FMA_RM_UP,
        FMA_RM_ZERO
    } fma_rmode_t;

endpackage

//--- logic/fma_class.sv
// operand classifier for the fused multiply-add block
// assumes a sign, biased exponent, fraction operand layout
`timescale 1ns/1ns

module fma_class #(
    parameter int EW = 8,
    parameter int FW = 23
) (
    // operand
    input  wire logic [EW+FW:0] i_op,
    // class
    output logic                o_nan,
    output logic                o_snan,
    output logic                o_inf,
    output logic                o_zero,
    output logic                o_sub,
    // quieted copy, significand, effective exponent
    output logic [EW+FW:0]      o_quiet,
    output logic [FW:0]         o_mant,
    output logic [EW-1:0]       o_exp
);

    logic ex_ones;
    logic ex_zero;
    logic fr_zero;

    ////////////////////////////////////////////////////////////////////////
    // field tests
    assign ex_ones = &i_op[EW+FW-1:FW];
    assign ex_zero = ~|i_op[EW+FW-1:FW];
    assign fr_zero = ~|i_op[FW-1:0];

    // class decode
    assign o_nan  = ex_ones & ~fr_zero;
    assign o_snan = o_nan & ~i_op[FW-1];
    assign o_inf  = ex_ones & fr_zero;
    assign o_zero = ex_zero & fr_zero;
    assign o_sub  = ex_zero & ~fr_zero;

    // quiet bit forced, sign and payload kept
    assign o_quiet = i_op | {{(EW+1){1'b0}}, 1'b1, {(FW-1){1'b0}}};

    // hidden bit and subnormal exponent of one
    assign o_mant = {~ex_zero, i_op[FW-1:0]};
    assign o_exp  = ex_zero ? EW'(1) : i_op[EW+FW-1:FW];

endmodule

//--- bench/fma_pipe_model.sv
// pipeline model: issues one operation to the block, collects the answer
// assumes the block answers at the same edge that takes a request
`timescale 1ns/1ns

module fma_pipe_model (
    // clock
    input  wire logic        i_clk,
    // request to the block
    output logic             o_valid,
    output logic             o_neg_prod,
    output logic             o_neg_add,
    output logic [1:0]       o_rmode,
    output logic [31:0]      o_x,
    output logic [31:0]      o_y,
    output logic [31:0]      o_z,
    output logic [31:0]      o_dst_old,
    output logic [4:0]       o_mask,
    // answer from the block
    input  wire logic        i_valid,
    input  wire logic [31:0] i_result,
    input  wire logic [4:0]  i_flags,
    input  wire logic        i_fault
);
    // idle request at time zero
    initial begin
        o_valid = 1'b0;
        o_neg_prod = 1'b0;
        o_neg_add = 1'b0;
        o_rmode = 2'h0;
        o_x = 32'h0;
        o_y = 32'h0;
        o_z = 32'h0;
        o_dst_old = 32'h0;
        o_mask = 5'h1F;
    end

    // hold request to the taking edge, then wait a bounded time for answer
    task automatic issue(input logic [1:0] f, rm, input logic [31:0] x, y,
                         z, input logic [4:0] mk, input logic [31:0] dst,
                         output logic [31:0] res, output logic [4:0] flg,
                         output logic flt, output bit seen);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_neg_prod <= f[1];
        o_neg_add <= f[0];
        o_rmode <= rm;
        o_x <= x;
        o_y <= y;
        o_z <= z;
        o_dst_old <= dst;
        o_mask <= mk;
        @(posedge i_clk);
        o_valid <= 1'b0;
        // released operands must not keep showing the old values
        o_x <= ~x;
        o_y <= ~y;
        o_z <= ~z;
        o_dst_old <= ~dst;
        seen = 1'b0;
        for (int i = 0; i < 4 && !seen; i++) begin
            #1;
            if (i_valid === 1'b1) begin
                seen = 1'b1;
                res = i_result;
                flg = i_flags;
                flt = i_fault;
            end else begin
                @(posedge i_clk);
            end
        end
    endtask
endmodule

//--- bench/tb_fused_multiply_add_special_cases.sv
// self-checking bench for the fused multiply-add result block
// assumes the pipeline model drives every operation request
`timescale 1ns/1ns

module tb_fused_multiply_add_special_cases;
    localparam logic [31:0] PINF = 32'h7F800000;
    localparam logic [31:0] NINF = 32'hFF800000;
    localparam logic [31:0] DNAN = 32'hFFC00000;
    localparam logic [31:0] ONE  = 32'h3F800000;
    localparam logic [31:0] TWO  = 32'h40000000;
    localparam logic [31:0] THR  = 32'h40400000;
    localparam logic [31:0] PZ   = 32'h00000000;
    localparam logic [31:0] NZ   = 32'h80000000;
    localparam logic [31:0] DST  = 32'h12345678;
    localparam logic [4:0]  ALL  = 5'h1F;

    logic        clk;
    logic        rst_n;
    logic        status_clr;
    logic [31:0] id_leaf;
    logic        rq_valid;
    logic        rq_neg_prod;
    logic        rq_neg_add;
    logic [1:0]  rq_rmode;
    logic [31:0] rq_x;
    logic [31:0] rq_y;
    logic [31:0] rq_z;
    logic [31:0] rq_dst;
    logic [4:0]  rq_mask;
    logic        rs_valid;
    logic [31:0] rs_result;
    logic [4:0]  rs_flags;
    logic        rs_fault;
    logic        inv_status;
    logic [31:0] id_word;
    int          n_mismatch;
    int          comparisons;
    int          cycles;

    ////////////////////////////////////////////////////////////////////////
    // block and pipeline model
    fma_special DUT (
        .i_clk(clk), .i_rstn(rst_n), .i_valid(rq_valid),
        .i_neg_prod(rq_neg_prod), .i_neg_add(rq_neg_add),
        .i_rmode(rq_rmode), .i_x(rq_x), .i_y(rq_y), .i_z(rq_z),
        .i_dst_old(rq_dst), .i_mask(rq_mask), .i_status_clr(status_clr),
        .i_id_leaf(id_leaf), .o_valid(rs_valid), .o_result(rs_result),
        .o_flags(rs_flags), .o_fault(rs_fault),
        .o_invalid_status(inv_status), .o_id_word(id_word)
    );

    fma_pipe_model pipe (
        .i_clk(clk), .o_valid(rq_valid), .o_neg_prod(rq_neg_prod),
        .o_neg_add(rq_neg_add), .o_rmode(rq_rmode), .o_x(rq_x),
        .o_y(rq_y), .o_z(rq_z), .o_dst_old(rq_dst), .o_mask(rq_mask),
        .i_valid(rs_valid), .i_result(rs_result), .i_flags(rs_flags),
        .i_fault(rs_fault)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and hang limit
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checking helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, want, input string m);
        comparisons++;
        if (got !== want) begin
            n_mismatch++;
            $display("ERROR at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask

    // one clear pulse, then the sticky flag must read low
    task automatic clr_status(input string m);
        @(posedge clk);
        status_clr <= 1'b1;
        @(posedge clk);
        status_clr <= 1'b0;
        #1;
        chk({31'h0, inv_status}, 32'h0, m);
    endtask

    // one operation; a trap must return the old destination
    task automatic op(input logic [1:0] f, rm, input logic [31:0] x, y, z,
                      input logic [4:0] mk, input logic [31:0] er,
                      input logic [4:0] ef);
        logic [31:0] res;
        logic [4:0]  flg;
        logic        flt;
        bit          seen;
        logic        xf;
        xf = |(ef & ~mk);
        pipe.issue(f, rm, x, y, z, mk, DST, res, flg, flt, seen);
        chk({31'h0, seen}, 32'h1, "no answer");
        chk(res, xf ? DST : er, "result");
        chk({27'h0, flg}, {27'h0, ef}, "flags");
        chk({31'h0, flt}, {31'h0, xf}, "fault");
    endtask

    // same operands in all four forms, masked; default NaN means invalid
    task automatic forms(input logic [1:0] rm, input logic [31:0] x, y, z,
                         input logic [127:0] ex, input logic [4:0] ef);
        logic [31:0] e;
        for (int f = 0; f < 4; f++) begin
            e = ex[127-32*f -: 32];
            op(f[1:0], rm, x, y, z, ALL, e, (e === DNAN) ? 5'h01 : ef);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_nan();
        forms(2'h0, 32'h7F800001, ONE, ONE, {4{32'h7FC00001}}, 5'h01);
        forms(2'h0, 32'hFFC00010, 32'h7F800001, ONE, {4{32'hFFC00010}},
              5'h01);
        forms(2'h0, ONE, 32'h7FC00002, ONE, {4{32'h7FC00002}}, 5'h00);
        forms(2'h0, ONE, 32'h7FC00002, 32'h7F800003, {4{32'h7FC00002}},
              5'h01);
        forms(2'h0, TWO, TWO, 32'hFF800005, {4{32'hFFC00005}}, 5'h01);
        $display("test nan done");
    endtask

    task automatic t_inf();
        forms(2'h0, PINF, TWO, PINF, {PINF, DNAN, DNAN, NINF}, 5'h0);
        forms(2'h0, PINF, TWO, NINF, {DNAN, PINF, NINF, DNAN}, 5'h0);
        forms(2'h0, PINF, 32'hC0000000, ONE, {NINF, NINF, PINF, PINF},
              5'h0);
        forms(2'h0, TWO, PINF, PZ, {PINF, PINF, NINF, NINF}, 5'h0);
        forms(2'h0, ONE, TWO, NINF, {NINF, PINF, NINF, PINF}, 5'h0);
        forms(2'h0, PINF, PZ, ONE, {4{DNAN}}, 5'h0);
        forms(2'h0, PZ, NINF, ONE, {4{DNAN}}, 5'h0);
        $display("test inf done");
    endtask

    task automatic t_zero();
        forms(2'h0, PZ, ONE, PZ, {PZ, PZ, PZ, NZ}, 5'h0);
        forms(2'h1, PZ, ONE, PZ, {PZ, NZ, NZ, NZ}, 5'h0);
        forms(2'h2, NZ, ONE, NZ, {NZ, PZ, PZ, PZ}, 5'h0);
        forms(2'h0, PZ, 32'h40A00000, THR, {THR, 32'hC0400000, THR,
              32'hC0400000}, 5'h0);
        for (int m = 0; m < 4; m++) begin
            forms(m[1:0], 32'h3FC00000, TWO, THR, {32'h40C00000,
                  (m == 1) ? NZ : PZ, (m == 1) ? NZ : PZ, 32'hC0C00000},
                  5'h0);
        end
        $display("test zero done");
    endtask

    task automatic t_finite();
        forms(2'h0, THR, 32'h3F000000, PZ, {{2{32'h3FC00000}},
              {2{32'hBFC00000}}}, 5'h0);
        op(2'h0, 2'h0, 32'h3F800800, 32'h3F800800, 32'hBF800000, ALL,
           32'h3A000400, 5'h00);
        op(2'h0, 2'h0, 32'h7F7FFFFF, TWO, PZ, ALL, PINF, 5'h14);
        op(2'h0, 2'h0, 32'h00800000, 32'h3F000001, PZ, ALL, 32'h00400000,
           5'h18);
        op(2'h0, 2'h3, 32'h7F7FFFFF, TWO, PZ, ALL, 32'h7F7FFFFF,
           5'h14);
        op(2'h0, 2'h2, ONE, ONE, 32'h30800000, ALL, 32'h3F800001,
           5'h10);
        $display("test finite done");
    endtask

    task automatic t_trap();
        clr_status("status clear before trap");
        op(2'h0, 2'h0, PINF, PZ, ONE, 5'h1E, DNAN, 5'h01);
        chk({31'h0, inv_status}, 32'h1, "status set");
        op(2'h0, 2'h0, ONE, ONE, 32'h30800000, 5'h0F, ONE, 5'h10);
        op(2'h0, 2'h0, 32'h00000001, ONE, PZ, 5'h1D, 32'h1, 5'h02);
        op(2'h0, 2'h0, 32'h7F7FFFFF, TWO, PZ, 5'h1B, PINF, 5'h14);
        clr_status("status clear");
        $display("test trap done");
    endtask

    task automatic t_ident();
        @(posedge clk);
        id_leaf <= 32'h00000001;
        @(posedge clk);
        #1;
        chk(id_word, 32'h00001000, "id leaf one");
        @(posedge clk);
        id_leaf <= 32'h00000007;
        @(posedge clk);
        #1;
        chk(id_word, 32'h0, "id other leaf");
        $display("test ident done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        rst_n = 1'b0;
        status_clr = 1'b0;
        id_leaf = 32'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({31'h0, rs_valid}, 32'h0, "valid after reset");
        chk({31'h0, inv_status}, 32'h0, "status after reset");
        $display("test reset done");
        t_nan();
        t_inf();
        t_zero();
        t_finite();
        t_trap();
        t_ident();
        close_out();
    end
endmodule
